// file: rtl/hpd_map.vh
`ifndef HPD_MAP_VH
`define HPD_MAP_VH

// ****************************************
// register indices (plain port, printed offsets)
// ****************************************
`define HPD_REG_MODE_CFG 16'h0293
`define HPD_REG_DET_CFG 16'h029B
`define HPD_REG_STATUS 16'h029C
`define HPD_REG_CODE_UP 16'h029D
`define HPD_REG_CODE_DN 16'h029F
`define HPD_REG_CAL_OFS 16'h31F8
`define HPD_REG_CAL_SLP 16'h31FA
`define HPD_WIDE_BASE 16'h3000

// ****************************************
// field positions
// ****************************************
`define HPD_PIN_SEL_BIT 13
`define HPD_MODE_MSB 2
`define HPD_MODE_LSB 0
`define HPD_SPAN_MSB 10
`define HPD_SPAN_LSB 9
`define HPD_CLKDIV_MSB 4
`define HPD_CLKDIV_LSB 3
`define HPD_STEP_MSB 2
`define HPD_STEP_LSB 1
`define HPD_TRIG_BIT 0
`define HPD_DONE_BIT 15
`define HPD_LVL_MSB 14

// ****************************************
// mode codes and reset values
// ****************************************
`define HPD_MODE_MIC_DISC 3'h0
`define HPD_MODE_HP_LEFT 3'h1
`define HPD_MODE_HP_RIGHT 3'h2
`define HPD_MODE_HP_MIC 3'h4
`define HPD_MODE_MIC_ADC 3'h7
`define HPD_MODE_CFG_RST 16'h0000
`define HPD_DET_CFG_RST 16'h0000
`define HPD_CODE_MAX 10'h3FF

// ****************************************
// timing
// ****************************************
`define HPD_CLK_HZ 250000000
`define HPD_SRC_HZ 32000
// clock over current-source rate, rounded down, sized to the divider parameter
`define HPD_SRC_TICK_CYC 16'h1E84

`endif

// file: rtl/hpd_impedance_detect.v
`timescale 1ns/1ps
`include "hpd_map.vh"

module hpd_impedance_detect #(
	parameter [15:0] SRC_TICK_CYC = `HPD_SRC_TICK_CYC
) (
	// clock, reset, enable
	input wire REF_CLK,
	input wire RST_N,
	input wire CE,
	// register port
	input wire [15:0] ADDR,
	input wire [31:0] WDATA,
	input wire WR,
	input wire RD,
	output reg [31:0] RDATA,
	// factory calibration fuses
	input wire [31:0] CAL_OFFSET,
	input wire [15:0] CAL_SLOPE,
	// analog front end
	input wire CMP_IN,
	input wire [14:0] LEVEL_IN,
	output wire [9:0] CUR_CODE,
	output wire SRC_TICK,
	output wire SWEEP_ACTIVE,
	output wire [1:0] SPAN_SEL,
	// sense pin steering
	output wire SENSE_LEFT_EN,
	output wire SENSE_RIGHT_EN,
	output wire SENSE_MIC1_EN,
	output wire SENSE_MIC2_EN,
	output wire FB_PIN2_SEL,
	// event to interrupt controller
	output wire DONE_EVT
);

	// ****************************************
	// states
	// ****************************************
	localparam [2:0] ST_IDLE = 3'h1;
	localparam [2:0] ST_UP = 3'h2;
	localparam [2:0] ST_DOWN = 3'h4;

	// ****************************************
	// configuration registers
	// ****************************************
	reg pin_sel_r;
	reg [2:0] mode_r;
	reg [1:0] span_r;
	reg [1:0] clkdiv_r;
	reg [1:0] step_sel_r;

	wire wr_mode = WR && (ADDR == `HPD_REG_MODE_CFG);
	wire wr_det = WR && (ADDR == `HPD_REG_DET_CFG);
	wire trig = wr_det && WDATA[`HPD_TRIG_BIT];

	always @(posedge REF_CLK) begin
		if (!RST_N) begin
			pin_sel_r <= 1'b0;
			mode_r <= 3'h0;
			span_r <= 2'h0;
			clkdiv_r <= 2'h0;
			step_sel_r <= 2'h0;
		end else if (CE) begin
			if (wr_mode) begin
				pin_sel_r <= WDATA[`HPD_PIN_SEL_BIT];
				mode_r <= WDATA[`HPD_MODE_MSB:`HPD_MODE_LSB];
			end
			if (wr_det) begin
				span_r <= WDATA[`HPD_SPAN_MSB:`HPD_SPAN_LSB];
				clkdiv_r <= WDATA[`HPD_CLKDIV_MSB:`HPD_CLKDIV_LSB];
				step_sel_r <= WDATA[`HPD_STEP_MSB:`HPD_STEP_LSB];
			end
		end
	end

	// ****************************************
	// mode decode and pin steering
	// ****************************************
	wire hp_lr = (mode_r == `HPD_MODE_HP_LEFT) || (mode_r == `HPD_MODE_HP_RIGHT);
	wire hp_mic = (mode_r == `HPD_MODE_HP_MIC);
	// mic detect and reserved codes never start the headphone sweep
	wire hp_mode = hp_lr || hp_mic;

	assign SENSE_LEFT_EN = (mode_r == `HPD_MODE_HP_LEFT);
	assign SENSE_RIGHT_EN = (mode_r == `HPD_MODE_HP_RIGHT);
	assign SENSE_MIC1_EN = hp_mic && !pin_sel_r;
	assign SENSE_MIC2_EN = hp_mic && pin_sel_r;
	assign FB_PIN2_SEL = pin_sel_r;
	// span only means something on the left and right pins
	assign SPAN_SEL = hp_lr ? span_r : 2'h0;

	// ****************************************
	// comparator synchroniser
	// ****************************************
	reg cmp_s1_r;
	reg cmp_s2_r;
	reg cmp_s3_r;
	reg cmp_r;

	always @(posedge REF_CLK) begin
		if (!RST_N) begin
			cmp_s1_r <= 1'b0;
			cmp_s2_r <= 1'b0;
			cmp_s3_r <= 1'b0;
			cmp_r <= 1'b0;
		end else if (CE) begin
			cmp_s1_r <= CMP_IN;
			cmp_s2_r <= cmp_s1_r;
			cmp_s3_r <= cmp_s2_r;
			// glitch filter: two settled stages must agree
			if (cmp_s2_r == cmp_s3_r) begin
				cmp_r <= cmp_s3_r;
			end
		end
	end

	// ****************************************
	// current-source clock divider
	// ****************************************
	reg [2:0] state_r;
	reg [17:0] tick_cnt_r;

	wire running = (state_r != ST_IDLE);
	wire [17:0] tick_lim = {2'h0, SRC_TICK_CYC} << clkdiv_r;
	wire tick = running && (tick_cnt_r == tick_lim - 18'h00001);

	always @(posedge REF_CLK) begin
		if (!RST_N) begin
			tick_cnt_r <= 18'h00000;
		end else if (CE) begin
			// restart phase on a trigger so each point gets a full period
			if (!running || trig || tick) begin
				tick_cnt_r <= 18'h00000;
			end else begin
				tick_cnt_r <= tick_cnt_r + 18'h00001;
			end
		end
	end

	assign SRC_TICK = tick;

	// ****************************************
	// sweep engine
	// ****************************************
	reg [9:0] code_r;
	reg [9:0] code_up_r;
	reg [9:0] code_dn_r;
	reg [14:0] level_r;
	reg done_r;
	reg done_evt_r;
	reg [2:0] state_nxt;
	reg [9:0] code_nxt;
	reg finish;
	reg up_cap;
	reg dn_cap;

	// reserved step code falls back to the finest step
	wire [9:0] step = (step_sel_r == 2'h1) ? 10'h002 :
		(step_sel_r == 2'h2) ? 10'h004 : 10'h001;
	wire [10:0] code_inc = {1'b0, code_r} + {1'b0, step};
	wire code_low = (code_r < step);

	always @* begin
		state_nxt = state_r;
		code_nxt = code_r;
		finish = 1'b0;
		up_cap = 1'b0;
		dn_cap = 1'b0;
		case (state_r)
			ST_IDLE: begin
				code_nxt = 10'h000;
			end
			ST_UP: begin
				if (tick) begin
					// trip or top of scale ends the rising sweep
					if (cmp_r || code_inc[10]) begin
						up_cap = 1'b1;
						state_nxt = ST_DOWN;
						code_nxt = `HPD_CODE_MAX;
					end else begin
						code_nxt = code_inc[9:0];
					end
				end
			end
			ST_DOWN: begin
				if (tick) begin
					if (!cmp_r || code_low) begin
						dn_cap = 1'b1;
						finish = 1'b1;
						state_nxt = ST_IDLE;
						code_nxt = 10'h000;
					end else begin
						code_nxt = code_r - step;
					end
				end
			end
			default: begin
				state_nxt = ST_IDLE;
				code_nxt = 10'h000;
			end
		endcase
		// a fresh trigger restarts the sweep unless this cycle completes
		if (trig && hp_mode && !finish) begin
			state_nxt = ST_UP;
			code_nxt = 10'h000;
		end
	end

	always @(posedge REF_CLK) begin
		if (!RST_N) begin
			state_r <= ST_IDLE;
			code_r <= 10'h000;
			code_up_r <= 10'h000;
			code_dn_r <= 10'h000;
			level_r <= 15'h0000;
			done_r <= 1'b0;
			done_evt_r <= 1'b0;
		end else if (CE) begin
			state_r <= state_nxt;
			code_r <= code_nxt;
			done_evt_r <= finish;
			if (up_cap) begin
				// mic-pin detect reports only the coarse level
				code_up_r <= hp_mic ? 10'h000 : code_r;
			end
			if (dn_cap) begin
				code_dn_r <= hp_mic ? 10'h000 : code_r;
				level_r <= LEVEL_IN;
			end
			// completion wins over a trigger in the same cycle
			if (finish) begin
				done_r <= 1'b1;
			end else if (trig && hp_mode) begin
				done_r <= 1'b0;
			end
		end
	end

	assign CUR_CODE = code_r;
	assign SWEEP_ACTIVE = running;
	assign DONE_EVT = done_evt_r;

	// ****************************************
	// read path
	// ****************************************
	reg [31:0] rd_nxt;

	always @* begin
		rd_nxt = 32'h00000000;
		if (ADDR == `HPD_REG_MODE_CFG) begin
			rd_nxt[`HPD_PIN_SEL_BIT] = pin_sel_r;
			rd_nxt[`HPD_MODE_MSB:`HPD_MODE_LSB] = mode_r;
		end else if (ADDR == `HPD_REG_DET_CFG) begin
			// trigger bit always reads back zero
			rd_nxt[`HPD_SPAN_MSB:`HPD_SPAN_LSB] = span_r;
			rd_nxt[`HPD_CLKDIV_MSB:`HPD_CLKDIV_LSB] = clkdiv_r;
			rd_nxt[`HPD_STEP_MSB:`HPD_STEP_LSB] = step_sel_r;
		end else if (ADDR == `HPD_REG_STATUS) begin
			rd_nxt[`HPD_DONE_BIT] = done_r;
			rd_nxt[`HPD_LVL_MSB:0] = level_r;
		end else if (ADDR == `HPD_REG_CODE_UP) begin
			rd_nxt[9:0] = code_up_r;
		end else if (ADDR == `HPD_REG_CODE_DN) begin
			rd_nxt[9:0] = code_dn_r;
		end else if (ADDR == `HPD_REG_CAL_OFS) begin
			rd_nxt = CAL_OFFSET;
		end else if (ADDR == `HPD_REG_CAL_SLP) begin
			rd_nxt[15:0] = CAL_SLOPE;
		end
	end

	always @(posedge REF_CLK) begin
		if (!RST_N) begin
			RDATA <= 32'h00000000;
		end else if (CE) begin
			// data valid only the cycle after the strobe
			if (RD) begin
				RDATA <= rd_nxt;
			end else begin
				RDATA <= 32'h00000000;
			end
		end
	end

endmodule // hpd_impedance_detect

// file: testbench/hpd_load_model.sv
`timescale 1ns/1ps
// ********
// headphone load seen by the source
// ********
module hpd_load_model #(
	parameter [9:0] THR = 10'h12D,
	parameter [14:0] LVL = 15'h0258
) (
	input wire [9:0] code,
	input wire [3:0] sense_en,
	output wire cmp,
	output wire [14:0] lvl
);
	// open jack when no pin senses, so no trip
	assign cmp = |sense_en && code >= THR;
	assign lvl = LVL;
endmodule // hpd_load_model

// file: testbench/hpd_impedance_detect_chk.sv
`timescale 1ns/1ps
`include "hpd_map.vh"
module hpd_impedance_detect_chk (
	// clock, reset and enable
	input wire REF_CLK,
	input wire RST_N,
	input wire CE,
	// register port
	input wire [15:0] ADDR,
	input wire [31:0] WDATA,
	input wire WR,
	input wire RD,
	input wire [31:0] RDATA,
	// calibration and analog
	input wire [31:0] CAL_OFFSET,
	input wire [15:0] CAL_SLOPE,
	input wire CMP_IN,
	input wire [14:0] LEVEL_IN,
	input wire [9:0] CUR_CODE,
	input wire SRC_TICK,
	input wire SWEEP_ACTIVE,
	input wire [1:0] SPAN_SEL,
	// steering and event
	input wire SENSE_LEFT_EN,
	input wire SENSE_RIGHT_EN,
	input wire SENSE_MIC1_EN,
	input wire SENSE_MIC2_EN,
	input wire FB_PIN2_SEL,
	input wire DONE_EVT
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	chk_evt_after_done: assert property ($fell(SWEEP_ACTIVE) |-> DONE_EVT)
		else $error("no done event");
	chk_idle_code: assert property (!SWEEP_ACTIVE |-> CUR_CODE == 10'h000)
		else $error("code while idle");
	chk_code_on_tick: assert property ($changed(CUR_CODE) |-> $past(SRC_TICK))
		else $error("code moved off tick");
	chk_tick_gap: assert property (SRC_TICK |-> SWEEP_ACTIVE ##1 !SRC_TICK [*4])
		else $error("tick spacing");
	chk_span_modes: assert property (SPAN_SEL != 2'h0 |-> SENSE_LEFT_EN || SENSE_RIGHT_EN)
		else $error("span outside hp mode");
	chk_one_sense: assert property ($onehot0({SENSE_LEFT_EN, SENSE_RIGHT_EN,
		SENSE_MIC1_EN, SENSE_MIC2_EN}))
		else $error("two sense pins");
	chk_mic_pin: assert property (SENSE_MIC1_EN || SENSE_MIC2_EN |-> SENSE_MIC2_EN == FB_PIN2_SEL)
		else $error("mic pin select");
	chk_narrow_read: assert property (RD && ADDR < `HPD_WIDE_BASE |=> RDATA[31:16] == 16'h0000)
		else $error("narrow read upper half");
	chk_trig_zero: assert property (RD && ADDR == `HPD_REG_DET_CFG |=> !RDATA[0])
		else $error("trigger reads one");
	chk_cal_word: assert property (RD && ADDR == `HPD_REG_CAL_OFS |=> RDATA == $past(CAL_OFFSET))
		else $error("offset word");
	cover property (DONE_EVT);
	cover property (SRC_TICK && CUR_CODE == 10'h3FF);
	cover property (SENSE_MIC1_EN && SWEEP_ACTIVE);
endmodule // hpd_impedance_detect_chk

// file: testbench/tb_headphone_impedance_detect.sv
`timescale 1ns/1ps
`include "hpd_map.vh"
module tb_headphone_impedance_detect;
	localparam [15:0] SRC_TICK_CYC = 16'h0008;
	localparam THR = 301;
	reg REF_CLK, RST_N, CE, WR, RD;
	reg [15:0] ADDR, CAL_SLOPE;
	reg [31:0] WDATA, CAL_OFFSET, v;
	wire [31:0] RDATA;
	wire [14:0] LEVEL_IN;
	wire [9:0] CUR_CODE;
	wire [1:0] SPAN_SEL;
	wire CMP_IN, SRC_TICK, SWEEP_ACTIVE, SENSE_LEFT_EN, SENSE_RIGHT_EN;
	wire SENSE_MIC1_EN, SENSE_MIC2_EN, FB_PIN2_SEL, DONE_EVT;
	integer err_count = 0, total_checks = 0, evt_n = 0, gap = 0, last_gap = 0, i;
	hpd_impedance_detect #(.SRC_TICK_CYC(SRC_TICK_CYC)) uut (
		.REF_CLK(REF_CLK), .RST_N(RST_N), .CE(CE),
		.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
		.CAL_OFFSET(CAL_OFFSET), .CAL_SLOPE(CAL_SLOPE),
		.CMP_IN(CMP_IN), .LEVEL_IN(LEVEL_IN), .CUR_CODE(CUR_CODE),
		.SRC_TICK(SRC_TICK), .SWEEP_ACTIVE(SWEEP_ACTIVE), .SPAN_SEL(SPAN_SEL),
		.SENSE_LEFT_EN(SENSE_LEFT_EN), .SENSE_RIGHT_EN(SENSE_RIGHT_EN),
		.SENSE_MIC1_EN(SENSE_MIC1_EN), .SENSE_MIC2_EN(SENSE_MIC2_EN),
		.FB_PIN2_SEL(FB_PIN2_SEL), .DONE_EVT(DONE_EVT)
	);
	hpd_load_model #(.THR(THR)) load (
		.code(CUR_CODE),
		.sense_en({SENSE_LEFT_EN, SENSE_RIGHT_EN, SENSE_MIC1_EN, SENSE_MIC2_EN}),
		.cmp(CMP_IN),
		.lvl(LEVEL_IN)
	);
	initial begin
		REF_CLK = 1'b0;
		forever #2 REF_CLK = ~REF_CLK;
	end
	always @(posedge REF_CLK) begin
		gap <= (SRC_TICK === 1'b1) ? 0 : gap + 1;
		if (SRC_TICK === 1'b1) last_gap <= gap + 1;
		if (DONE_EVT === 1'b1) evt_n <= evt_n + 1;
	end
	task report_and_stop;
		begin
			$display("checks %0d errors %0d", total_checks, err_count);
			if (err_count == 0 && total_checks > 0) $display("TB: PASS");
			else $display("TB: FAIL");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("mismatch at %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task wr(input [15:0] a, input [31:0] d);
		begin
			@(posedge REF_CLK);
			ADDR <= a;
			WDATA <= d;
			WR <= 1'b1;
			@(posedge REF_CLK);
			WR <= 1'b0;
			#1;
		end
	endtask
	task rd(input [15:0] a);
		begin
			@(posedge REF_CLK);
			ADDR <= a;
			RD <= 1'b1;
			@(posedge REF_CLK);
			RD <= 1'b0;
			#1 v = RDATA;
		end
	endtask
	task rchk(input [15:0] a, input [31:0] e);
		begin
			rd(a);
			chk(v, e);
		end
	endtask
	task meas(input [2:0] md, input [15:0] cfg);
		integer s, n, e, u, eu, ed;
		begin
			s = cfg[2:1] == 2'h2 ? 4 : cfg[2:1] == 2'h1 ? 2 : 1;
			eu = md[2] ? 0 : (THR + s - 1) / s * s;
			ed = md[2] ? 0 : 1023 - s * ((1023 - THR) / s + 1);
			e = evt_n;
			wr(`HPD_REG_MODE_CFG, {29'h0, md});
			wr(`HPD_REG_DET_CFG, {16'h0, cfg} | 32'h1);
			chk(SWEEP_ACTIVE, 1'b1);
			rd(`HPD_REG_STATUS);
			chk(v[15], 1'b0);
			rchk(`HPD_REG_DET_CFG, {16'h0, cfg});
			n = 0;
			while (v[15] !== 1'b1 && n < 20000) begin
				rd(`HPD_REG_STATUS);
				n = n + 1;
			end
			chk(v, 32'h8258);
			rchk(`HPD_REG_CODE_UP, eu);
			u = v;
			chk(md[2] || (u >= 10'h0A9 && u <= 10'h3FB), 1'b1);
			rchk(`HPD_REG_CODE_DN, ed);
			// decode works on the exact sum, so no half code is lost
			chk(u + v, eu + ed);
			chk(evt_n, e + 1);
			chk(last_gap, SRC_TICK_CYC << cfg[4:3]);
			wr(`HPD_REG_DET_CFG, {16'h0, cfg});
			rd(`HPD_REG_STATUS);
			chk(v[15], 1'b1);
		end
	endtask
	initial begin
		#300000;
		err_count = err_count + 1;
		report_and_stop;
	end
	initial begin
		RST_N = 1'b0;
		CE = 1'b1;
		WR = 1'b0;
		RD = 1'b0;
		ADDR = 16'h0000;
		WDATA = 32'h0;
		CAL_OFFSET = 32'h81F47F0C;
		CAL_SLOPE = 16'h7F83;
		repeat (6) @(posedge REF_CLK);
		RST_N <= 1'b1;
		rchk(`HPD_REG_MODE_CFG, 32'h0);
		rchk(`HPD_REG_DET_CFG, 32'h0);
		rchk(`HPD_REG_STATUS, 32'h0);
		rchk(`HPD_REG_CODE_UP, 32'h0);
		rchk(`HPD_REG_CODE_DN, 32'h0);
		rchk(`HPD_REG_CAL_OFS, 32'h81F47F0C);
		rchk(`HPD_REG_CAL_SLP, 32'h00007F83);
		wr(16'h0294, 32'hFFFF);
		rchk(16'h0294, 32'h0);
		wr(`HPD_REG_DET_CFG, 32'h0600);
		for (i = 0; i < 16; i = i + 1) begin
			wr(`HPD_REG_MODE_CFG, {18'h0, i[3], 10'h0, i[2:0]});
			chk({SENSE_LEFT_EN, SENSE_RIGHT_EN, SENSE_MIC1_EN, SENSE_MIC2_EN, FB_PIN2_SEL, SPAN_SEL},
				{i[2:0] == 3'h1, i[2:0] == 3'h2, i[2:0] == 3'h4 && !i[3], i[2:0] == 3'h4 && i[3],
				i[3], (i[2:0] == 3'h1 || i[2:0] == 3'h2) ? 2'h3 : 2'h0});
			if (i[2:0] != 3'h1 && i[2:0] != 3'h2 && i[2:0] != 3'h4) begin
				wr(`HPD_REG_DET_CFG, 32'h0601);
				chk(SWEEP_ACTIVE, 1'b0);
			end
		end
		meas(3'h1, 16'h0000);
		meas(3'h2, 16'h020A);
		meas(3'h1, 16'h0414);
		meas(3'h4, 16'h061C);
		report_and_stop;
	end
endmodule // tb_headphone_impedance_detect
bind hpd_impedance_detect hpd_impedance_detect_chk chk_i (
	.REF_CLK(REF_CLK), .RST_N(RST_N), .CE(CE),
	.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
	.CAL_OFFSET(CAL_OFFSET), .CAL_SLOPE(CAL_SLOPE),
	.CMP_IN(CMP_IN), .LEVEL_IN(LEVEL_IN), .CUR_CODE(CUR_CODE),
	.SRC_TICK(SRC_TICK), .SWEEP_ACTIVE(SWEEP_ACTIVE), .SPAN_SEL(SPAN_SEL),
	.SENSE_LEFT_EN(SENSE_LEFT_EN), .SENSE_RIGHT_EN(SENSE_RIGHT_EN),
	.SENSE_MIC1_EN(SENSE_MIC1_EN), .SENSE_MIC2_EN(SENSE_MIC2_EN),
	.FB_PIN2_SEL(FB_PIN2_SEL), .DONE_EVT(DONE_EVT)
);
